// >>> riv_voter.sv
// top of the redundant input voter: discrete 2oo3 vote, analog mid-value,
// discrepancy flags, single-source pass-through and scan pacing
// assumes source buses deliver words with one-cycle strobes on mclk
// assumes execReq comes from the consuming logic before each execution cycle
// How it works
// R1 - discrete bits voted two of three majority
// R2 - two sources: duplex state is third vote
// R3 - one source, 3210 mode: use it
// R4 - one source, 320 mode: use default
// R5 - per point autotest, default, degrade settings
// R6 - three analog samples: pick middle value
// R7 - analog degrades to single or default
// R8 - flag discrete points and analog sources disagreeing with voted result
// R9 - single ungrouped source passes through unvoted
// R10 - each source broadcasts once per scan
// R11 - vote done before each execution starts
// R12 - absent means no fresh word this scan
// R13 - two analog: lower address unless configured
`timescale 1ns/1ns
`include "riv_regs.svh"
module riv_voter
    import riv_pkg::*;
#(
    parameter int NPTS      = `RIV_NPTS,
    parameter int AW        = `RIV_AW,
    parameter int SCAN_NS   = `RIV_SCAN_NS,
    parameter int SCAN_CYC  = SCAN_NS / `RIV_CLK_NS
) (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic [2:0]          dArrive,
    input  wire logic [NPTS-1:0]     dIn0,
    input  wire logic [NPTS-1:0]     dIn1,
    input  wire logic [NPTS-1:0]     dIn2,
    input  wire logic [2:0]          aArrive,
    input  wire logic [AW-1:0]       aIn0,
    input  wire logic [AW-1:0]       aIn1,
    input  wire logic [AW-1:0]       aIn2,
    input  wire logic                sArrive,
    input  wire logic [NPTS-1:0]     sIn,
    input  wire riv_dcfg_s           dCfg,
    input  wire riv_acfg_s           aCfg,
    input  wire logic                execReq,
    output logic                     execGo,
    output logic [NPTS-1:0]          dVoted,
    output logic [AW-1:0]            aVoted,
    output logic [NPTS-1:0]          sPass,
    output logic [NPTS-1:0]          dDiscrep,
    output logic [2:0]               aDiscrep,
    output logic [2:0]               dPresent,
    output logic [2:0]               aPresent,
    output logic [NPTS-1:0]          autotestSel,
    output logic                     resultValid
);
    localparam int NSRC = `RIV_NSRC;

    // latest words per source; a missing arrival keeps the stale copy, which presence masks
    logic [NPTS-1:0] dHold      [NSRC];
    logic [AW-1:0]   aHold      [NSRC];
    logic [NPTS-1:0] next_dHold [NSRC];
    logic [AW-1:0]   next_aHold [NSRC];
    logic [NPTS-1:0] sHold;
    logic [NPTS-1:0] next_sHold;

    logic [31:0] scanCnt;
    logic [31:0] next_scanCnt;
    logic        scanTick;

    riv_state_e      state;
    riv_state_e      next_state;
    logic            next_execGo;
    logic [NPTS-1:0] next_dVoted;
    logic [AW-1:0]   next_aVoted;
    logic [NPTS-1:0] next_sPass;
    logic [NPTS-1:0] next_dDiscrep;
    logic [2:0]      next_aDiscrep;
    logic            next_resultValid;
    logic [2:0]      next_dPresent;
    logic [2:0]      next_aPresent;
    logic [NPTS-1:0] next_autotestSel;

    logic [2:0]      dPres;
    logic [2:0]      aPres;
    logic [AW-1:0]   aMid;
    logic [NPTS-1:0] dComb;
    logic [NPTS-1:0] dDisNow;
    logic [2:0]      aDisNow;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [1:0] count3(input logic [2:0] p);
        count3 = {1'b0, p[0]} + {1'b0, p[1]} + {1'b0, p[2]};
    endfunction

    function automatic logic voteIn(input logic pres, input logic word, input logic duplex);
        voteIn = pres ? word : duplex;
    endfunction

    function automatic logic [NPTS-1:0] disagree(input logic [NPTS-1:0] word, input logic [NPTS-1:0] voted,
                                                 input logic pres);
        disagree = (word ^ voted) & {NPTS{pres}};
    endfunction

    // one present source: the masked or of all slots is that source's bit
    function automatic logic onlyOne(input logic [2:0] pres, input logic b0, input logic b1, input logic b2);
        onlyOne = (pres[0] & b0) | (pres[1] & b1) | (pres[2] & b2);
    endfunction

    // limitation: a dropped source is still counted until the next scan tick closes its period
    riv_freshness #(.NSRC(NSRC)) uDFresh (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .scanTick (scanTick),
        .arrive   (dArrive),
        .present  (dPres)
    );

    riv_freshness #(.NSRC(NSRC)) uAFresh (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .scanTick (scanTick),
        .arrive   (aArrive),
        .present  (aPres)
    );

    riv_mid_select #(.AW(AW)) uMid (
        .s0      (aHold[0]),
        .s1      (aHold[1]),
        .s2      (aHold[2]),
        .present (aPres),
        .cfg     (aCfg),
        .result  (aMid)
    );

    // scan period divider
    always_comb begin
        scanTick     = (scanCnt == 32'(SCAN_CYC - 1));
        next_scanCnt = scanCnt + 32'h1;
        if (scanTick) begin
            next_scanCnt = `RIV_RST_CNT;
        end
    end

    // capture the broadcast words; each source refreshes once per scan
    // a second arrival within one scan simply overwrites the first
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            next_dHold[i] = dHold[i];
            next_aHold[i] = aHold[i];
        end
        next_sHold = sHold;
        if (dArrive[0]) next_dHold[0] = dIn0;   // see R10
        if (dArrive[1]) next_dHold[1] = dIn1;
        if (dArrive[2]) next_dHold[2] = dIn2;
        if (aArrive[0]) next_aHold[0] = aIn0;
        if (aArrive[1]) next_aHold[1] = aIn1;
        if (aArrive[2]) next_aHold[2] = aIn2;
        if (sArrive)    next_sHold    = sIn;
    end

    // discrete vote per point, selected by present-source count
    always_comb begin
        dComb = dCfg.defaultState;
        for (int p = 0; p < NPTS; p++) begin
            case (count3(dPres))   // see R12
                2'h3: dComb[p] = maj3(dHold[0][p], dHold[1][p], dHold[2][p]);   // see R1
                2'h2: begin
                    // absent source slot takes the duplex state as the third vote
                    dComb[p] = maj3(voteIn(dPres[0], dHold[0][p], dCfg.duplexState[p]),
                                    voteIn(dPres[1], dHold[1][p], dCfg.duplexState[p]),
                                    voteIn(dPres[2], dHold[2][p], dCfg.duplexState[p]));   // see R2
                end
                2'h1: begin
                    if (dCfg.degradeMode[p] == `RIV_MODE_3210) begin
                        dComb[p] = onlyOne(dPres, dHold[0][p], dHold[1][p], dHold[2][p]);   // see R3
                    end else begin
                        dComb[p] = dCfg.defaultState[p];   // see R4
                    end
                end
                // no source present: the default state, as in the one-source 320 mode case
                default: dComb[p] = dCfg.defaultState[p];
            endcase
        end
    end

    // disagreement against the vote about to be latched; absent sources never flag
    always_comb begin
        dDisNow = disagree(dHold[0], dComb, dPres[0])
                | disagree(dHold[1], dComb, dPres[1])
                | disagree(dHold[2], dComb, dPres[2]);   // see R8
        for (int i = 0; i < NSRC; i++) begin
            aDisNow[i] = aPres[i] & (aHold[i] != aMid);   // see R8
        end
    end

    // execution handshake: the vote is latched before execGo is granted
    // idle takes the request, vote latches, ready raises the one-cycle start pulse;
    // a request during vote or ready is dropped, not queued
    always_comb begin
        next_state       = state;
        next_execGo      = 1'b0;
        next_dVoted      = dVoted;
        next_aVoted      = aVoted;
        next_sPass       = sPass;
        next_dDiscrep    = dDiscrep;
        next_aDiscrep    = aDiscrep;
        next_resultValid = resultValid;
        case (state)
            RIV_IDLE: begin
                if (execReq) begin
                    next_state = RIV_VOTE;
                end
            end
            RIV_VOTE: begin
                next_dVoted = dComb;               // see R11
                next_aVoted = aMid;
                next_sPass  = sHold;               // see R9
                next_dDiscrep = dDisNow;
                next_aDiscrep = aDisNow;
                next_resultValid = 1'b1;
                next_state       = RIV_READY;
            end
            RIV_READY: begin
                next_execGo = 1'b1;                // see R11
                next_state  = RIV_IDLE;
            end
            default: next_state = RIV_IDLE;
        endcase
    end

    // source word store
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NSRC; i++) begin
                dHold[i] <= `RIV_RST_BITS;
                aHold[i] <= `RIV_RST_WORD;
            end
            sHold <= `RIV_RST_BITS;
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                dHold[i] <= next_dHold[i];
                aHold[i] <= next_aHold[i];
            end
            sHold <= next_sHold;
        end
    end

    // scan period counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scanCnt <= `RIV_RST_CNT;
        end else begin
            scanCnt <= next_scanCnt;
        end
    end

    // handshake state and latched results
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= RIV_IDLE;
            execGo      <= 1'b0;
            dVoted      <= `RIV_RST_BITS;
            aVoted      <= `RIV_RST_WORD;
            sPass       <= `RIV_RST_BITS;
            dDiscrep    <= `RIV_RST_BITS;
            aDiscrep    <= `RIV_RST_SRC;
            resultValid <= 1'b0;
        end else begin
            state       <= next_state;
            execGo      <= next_execGo;
            dVoted      <= next_dVoted;
            aVoted      <= next_aVoted;
            sPass       <= next_sPass;
            dDiscrep    <= next_dDiscrep;
            aDiscrep    <= next_aDiscrep;
            resultValid <= next_resultValid;
        end
    end

    // status mirrors: registered so that every output leaves a flip-flop,
    // at the cost of showing presence one cycle after the vote logic sees it
    always_comb begin
        next_dPresent    = dPres;
        next_aPresent    = aPres;
        next_autotestSel = dCfg.autotestEn;   // see R5
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dPresent    <= `RIV_RST_SRC;
            aPresent    <= `RIV_RST_SRC;
            autotestSel <= `RIV_RST_BITS;
        end else begin
            dPresent    <= next_dPresent;
            aPresent    <= next_aPresent;
            autotestSel <= next_autotestSel;
        end
    end
endmodule

// >>> riv_regs.svh
// constants for the redundant input voter
// assumes inclusion by bare name from package and modules
`ifndef RIV_REGS_SVH
`define RIV_REGS_SVH
`define RIV_NPTS        8
`define RIV_AW          12
`define RIV_NSRC        3
`define RIV_SCAN_NS     10000000
`define RIV_CLK_NS      100
`define RIV_MODE_3210   1'b0
`define RIV_MODE_320    1'b1
`define RIV_RST_BITS    8'h00
`define RIV_RST_WORD    12'h000
`define RIV_RST_SRC     3'h0
`define RIV_RST_CNT     32'h0
`endif

// >>> riv_pkg.sv
// types for the redundant input voter
// assumes riv_regs.svh is on the include path
`include "riv_regs.svh"
package riv_pkg;
    // per discrete point settings
    typedef struct packed {
        logic [`RIV_NPTS-1:0] autotestEn;
        logic [`RIV_NPTS-1:0] defaultState;
        logic [`RIV_NPTS-1:0] duplexState;
        logic [`RIV_NPTS-1:0] degradeMode;
    } riv_dcfg_s;
    // analog group settings
    typedef struct packed {
        logic [`RIV_AW-1:0] defaultValue;
        logic               degradeMode;
        logic               pickHigherAddr;
    } riv_acfg_s;
    typedef enum logic [2:0] {
        RIV_IDLE  = 3'b001,
        RIV_VOTE  = 3'b010,
        RIV_READY = 3'b100
    } riv_state_e;
    typedef logic [`RIV_NSRC-1:0] riv_src_t;
endpackage

// >>> riv_freshness.sv
// per source freshness tracking over one scan period
// assumes arrival strobes are one-cycle pulses synchronous to mclk
`timescale 1ns/1ns
`include "riv_regs.svh"
module riv_freshness
    import riv_pkg::*;
#(
    parameter int NSRC = `RIV_NSRC
) (
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            scanTick,
    input  wire logic [NSRC-1:0] arrive,
    output logic      [NSRC-1:0] present
);
    logic [NSRC-1:0] seen;
    logic [NSRC-1:0] next_seen;
    logic [NSRC-1:0] next_present;

    // arrival in the tick cycle counts toward the period just closing
    always_comb begin
        next_seen    = seen | arrive;
        next_present = present;
        if (scanTick) begin
            next_present = seen | arrive;   // see R12
            next_seen    = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            seen    <= '0;
            present <= '0;
        end else begin
            seen    <= next_seen;
            present <= next_present;
        end
    end
endmodule

// >>> riv_mid_select.sv
// combinational mid-value and degradation for analog samples
// assumes inputs are stable for the cycle they are sampled
`timescale 1ns/1ns
`include "riv_regs.svh"
module riv_mid_select
    import riv_pkg::*;
#(
    parameter int AW = `RIV_AW
) (
    input  wire logic [AW-1:0] s0,
    input  wire logic [AW-1:0] s1,
    input  wire logic [AW-1:0] s2,
    input  wire logic [2:0]    present,
    input  wire riv_acfg_s     cfg,
    output logic      [AW-1:0] result
);
    function automatic logic [AW-1:0] mid3(input logic [AW-1:0] a, input logic [AW-1:0] b,
                                           input logic [AW-1:0] c);
        logic [AW-1:0] lo;
        logic [AW-1:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        if (c <= lo)      mid3 = lo;
        else if (c >= hi) mid3 = hi;
        else              mid3 = c;
    endfunction

    always_comb begin
        result = cfg.defaultValue;
        case (present)
            3'h7: result = mid3(s0, s1, s2);                        // see R6
            3'h3: result = cfg.pickHigherAddr ? s1 : s0;            // see R13
            3'h5: result = cfg.pickHigherAddr ? s2 : s0;            // see R13
            3'h6: result = cfg.pickHigherAddr ? s2 : s1;            // see R13
            3'h1: result = (cfg.degradeMode == `RIV_MODE_3210) ? s0 : cfg.defaultValue;  // see R7
            3'h2: result = (cfg.degradeMode == `RIV_MODE_3210) ? s1 : cfg.defaultValue;  // see R7
            3'h4: result = (cfg.degradeMode == `RIV_MODE_3210) ? s2 : cfg.defaultValue;  // see R7
            default: result = cfg.defaultValue;
        endcase
    end
endmodule

// >>> riv_voter_assertions.sv
// checker for the voter top, bound onto riv_voter
// assumes source words stay steady around a vote
`timescale 1ns/1ns
module riv_voter_chk #(
    parameter int NPTS = 8,
    parameter int AW   = 12
) (
    input wire logic            mclk,
    input wire logic            rst_b,
    input wire logic [2:0]      dArrive,
    input wire logic [NPTS-1:0] dIn0,
    input wire logic [NPTS-1:0] dIn1,
    input wire logic [NPTS-1:0] dIn2,
    input wire logic [2:0]      aArrive,
    input wire logic [AW-1:0]   aIn0,
    input wire logic [AW-1:0]   aIn1,
    input wire logic [AW-1:0]   aIn2,
    input wire logic            execReq,
    input wire logic            execGo,
    input wire logic [NPTS-1:0] dVoted,
    input wire logic [AW-1:0]   aVoted,
    input wire logic [NPTS-1:0] dDiscrep,
    input wire logic [2:0]      dPresent,
    input wire logic [2:0]      aPresent,
    input wire logic            resultValid
);
    logic [NPTS-1:0] h0, h1, h2, dMaj, dDis;
    logic [AW-1:0]   g0, g1, g2, gMid;
    logic [2:0]      quiet;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge mclk) begin
        h0 <= dArrive[0] ? dIn0 : h0;
        h1 <= dArrive[1] ? dIn1 : h1;
        h2 <= dArrive[2] ? dIn2 : h2;
        g0 <= aArrive[0] ? aIn0 : g0;
        g1 <= aArrive[1] ? aIn1 : g1;
        g2 <= aArrive[2] ? aIn2 : g2;
    end
    // value checks only run when no word or presence moved near the vote
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            quiet <= 3'h0;
        else if ((|{dArrive, aArrive}) || $changed(dPresent) || $changed(aPresent))
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    always_comb begin
        dMaj = (h0 & h1) | (h0 & h2) | (h1 & h2);
        dDis = ({NPTS{dPresent[0]}} & (h0 ^ dVoted)) | ({NPTS{dPresent[1]}} & (h1 ^ dVoted))
             | ({NPTS{dPresent[2]}} & (h2 ^ dVoted));
        gMid = (g0 > g1) ? ((g1 > g2) ? g1 : ((g0 > g2) ? g2 : g0)) : ((g0 > g2) ? g0 : ((g1 > g2) ? g2 : g1));
    end
    AST_EXEC_ANSWER: assert property (execReq |-> ##[1:4] execGo)
        else $error("vote request got no start pulse");
    AST_GO_ONE: assert property (execGo |=> !execGo)
        else $error("start pulse longer than one cycle");
    AST_GO_VALID: assert property (execGo |-> resultValid)
        else $error("start pulse without valid results");
    AST_VALID_KEEP: assert property (resultValid |=> resultValid)
        else $error("result valid dropped");
    AST_HOLD: assert property (($changed(dVoted) || $changed(aVoted)) |=> execGo)
        else $error("results moved outside a vote");
    AST_MAJ3: assert property ((execGo && quiet > 3'h4 && dPresent == 3'h7) |-> dVoted == dMaj)
        else $error("discrete majority wrong");
    AST_DDISC: assert property ((execGo && quiet > 3'h4) |-> dDiscrep == dDis)
        else $error("discrete discrepancy flags wrong");
    AST_MID3: assert property ((execGo && quiet > 3'h4 && aPresent == 3'h7) |-> aVoted == gMid)
        else $error("analog middle value wrong");
    COV_THREE: cover property (execGo && dPresent == 3'h7);
    COV_TWO: cover property (execGo && $countones(aPresent) == 2);
    COV_NONE: cover property (execGo && dPresent == 3'h0);
endmodule
bind riv_voter riv_voter_chk #(.NPTS(NPTS), .AW(AW)) chk_u (.mclk, .rst_b, .dArrive, .dIn0, .dIn1, .dIn2,
    .aArrive, .aIn0, .aIn1, .aIn2, .execReq, .execGo, .dVoted, .aVoted, .dDiscrep, .dPresent, .aPresent,
    .resultValid);

// >>> riv_src_model.sv
// far-side source blocks: three discrete, three analog, one single
// assumes words are steady while a source is enabled
`timescale 1ns/1ns
module riv_src_model (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic [2:0]       dEn,
    input  wire logic [2:0]       aEn,
    input  wire logic [2:0][7:0]  dW,
    input  wire logic [2:0][11:0] aW,
    input  wire logic [7:0]       sW,
    output logic      [2:0]       dArrive,
    output logic      [2:0]       aArrive,
    output logic                  sArrive,
    output logic      [2:0][7:0]  dOut,
    output logic      [2:0][11:0] aOut,
    output logic      [7:0]       sOut
);
    int phase;
    // lines toggle between strobes so a stale copy never looks valid
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 0;
            dArrive <= 3'h0;
            aArrive <= 3'h0;
            sArrive <= 1'b0;
            dOut <= '0;
            aOut <= '0;
            sOut <= 8'h00;
        end else begin
            phase <= (phase == 19) ? 0 : phase + 1;
            dArrive <= (phase == 3) ? dEn : 3'h0;
            aArrive <= (phase == 3) ? aEn : 3'h0;
            sArrive <= (phase == 3);
            dOut <= (phase == 3) ? dW : ~dOut;
            aOut <= (phase == 3) ? aW : ~aOut;
            sOut <= (phase == 3) ? sW : ~sOut;
        end
    end
endmodule

// >>> tb_top.sv
// bench: sweeps source presence and voting modes
// assumes a scan period of 20 clocks in the voter
`timescale 1ns/1ns
module tb_top
    import riv_pkg::*;
;
    logic             mclk = 1'b0, rst_b = 1'b0, execReq = 1'b0, sArrive, execGo, resultValid;
    logic [2:0]       dEn = 3'h7, aEn = 3'h7, dArrive, aArrive, dPresent, aPresent, aDiscrep, pat, ad;
    logic [2:0][7:0]  dW = {8'hf0, 8'hcc, 8'haa}, dIn;
    logic [2:0][11:0] aW = {12'h0f3, 12'h1a5, 12'h3c0}, aIn;
    logic [7:0]       sW = 8'h00, sIn, dVoted, sPass, dDiscrep, autotestSel, dd, prev = 8'h00;
    logic [11:0]      aVoted, av;
    riv_dcfg_s        dCfg = {8'h3c, 8'h96, 8'h5a, 8'h0f};
    riv_acfg_s        aCfg = {12'h7e1, 1'b0, 1'b0};
    int               error_cnt = 0, compares = 0, goCnt = 0;
    riv_src_model src_u (.mclk, .rst_b, .dEn, .aEn, .dW, .aW, .sW, .dArrive, .aArrive, .sArrive,
        .dOut(dIn), .aOut(aIn), .sOut(sIn));
    riv_voter #(.SCAN_CYC(20)) dut_u (.mclk, .rst_b, .dArrive, .dIn0(dIn[0]), .dIn1(dIn[1]), .dIn2(dIn[2]),
        .aArrive, .aIn0(aIn[0]), .aIn1(aIn[1]), .aIn2(aIn[2]), .sArrive, .sIn, .dCfg, .aCfg, .execReq,
        .execGo, .dVoted, .aVoted, .sPass, .dDiscrep, .aDiscrep, .dPresent, .aPresent, .autotestSel,
        .resultValid);
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) if (execGo === 1'b1) goCnt++;
    function automatic logic [7:0] dexp(input logic [2:0] p);
        logic [7:0] s0, s1, s2, one;
        s0 = p[0] ? dW[0] : dCfg.duplexState;
        s1 = p[1] ? dW[1] : dCfg.duplexState;
        s2 = p[2] ? dW[2] : dCfg.duplexState;
        one = p[0] ? dW[0] : (p[1] ? dW[1] : dW[2]);
        if ($countones(p) >= 2) return (s0 & s1) | (s0 & s2) | (s1 & s2);
        if (p == 3'h0) return dCfg.defaultState;
        return (one & ~dCfg.degradeMode) | (dCfg.defaultState & dCfg.degradeMode);
    endfunction
    function automatic logic [11:0] aexp(input logic [2:0] p);
        logic [11:0] a, b, c;
        {c, b, a} = aW;
        case ($countones(p))
            3: return (a > b) ? ((b > c) ? b : ((a > c) ? c : a)) : ((a > c) ? a : ((b > c) ? c : b));
            2: return aCfg.pickHigherAddr ? (p[2] ? c : b) : (p[0] ? a : b);
            1: return aCfg.degradeMode ? aCfg.defaultValue : (p[0] ? a : (p[1] ? b : c));
            default: return aCfg.defaultValue;
        endcase
    endfunction
    task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic vote();
        int n;
        @(posedge mclk) execReq <= 1'b1;
        @(posedge mclk) execReq <= 1'b0;
        for (n = 0; n < 8; n++) begin
            @(posedge mclk);
            #1;
            if (execGo === 1'b1) break;
        end
        if (n == 8) begin
            error_cnt++;
            summarize();
        end
    endtask
    initial begin
        int n;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        chk("resultValid", resultValid, 12'h0);
        $display("reset test done");
        for (int c = 0; c < 2; c++) begin
            @(posedge mclk);
            aCfg <= c ? {12'h7e1, 1'b1, 1'b1} : {12'h7e1, 1'b0, 1'b0};
            for (int k = 0; k < 8; k++) begin
                pat = 3'(7 - k);
                @(posedge mclk);
                dEn <= pat;
                aEn <= pat;
                sW <= 8'h5a ^ 8'(k);
                dW[2] <= 8'hf0 ^ 8'(k);
                repeat (50) @(posedge mclk);
                #1;
                chk("held", dVoted, prev);
                chk("dPresent", dPresent, pat);
                chk("aPresent", aPresent, pat);
                vote();
                prev = dexp(pat);
                av = aexp(pat);
                dd = 8'h00;
                for (int i = 0; i < 3; i++) begin
                    dd = dd | (pat[i] ? dW[i] ^ prev : 8'h00);
                    ad[i] = pat[i] && aW[i] != av;
                end
                chk("dVoted", dVoted, prev);
                chk("dDiscrep", dDiscrep, dd);
                chk("aVoted", aVoted, av);
                chk("aDiscrep", aDiscrep, ad);
                chk("sPass", sPass, sW);
                chk("autotestSel", autotestSel, dCfg.autotestEn);
            end
            $display("vote sweep %0d done", c);
        end
        repeat (2) @(posedge mclk);
        #1;
        n = goCnt;
        @(posedge mclk);
        execReq <= 1'b1;
        repeat (3) @(posedge mclk);
        execReq <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("goCount", 12'(goCnt - n), 12'h1);
        $display("busy request test done");
        summarize();
    end
endmodule
